/* File: design/agc_pkg.sv */
package agc_pkg;

  // ----------------------------------------------------------------
  // pixel and frame geometry
  // ----------------------------------------------------------------
  localparam int PIX_W = 14;
  localparam int OUT_W = 8;
  localparam int BINS = 16384;
  localparam int IDX_W = 14;
  localparam int COLS = 80;
  localparam int ROWS = 60;
  localparam int COL_W = 7;
  localparam int ROW_W = 6;
  localparam int CNT_W = 16;
  localparam int ACC_W = 32;
  localparam int FIFO_DEPTH = 4;
  localparam logic [COL_W-1:0] LAST_COL = 7'h4F;
  localparam logic [ROW_W-1:0] LAST_ROW = 6'h3B;
  localparam logic [IDX_W-1:0] LAST_IDX = 14'h3FFF;
  localparam logic [7:0] GRAY_MAX = 8'hFF;

  // ----------------------------------------------------------------
  // register port: indices, fields, reset values
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] REG_ROI_COL0 = 4'h2;
  localparam logic [ADDR_W-1:0] REG_ROI_ROW0 = 4'h3;
  localparam logic [ADDR_W-1:0] REG_ROI_COL1 = 4'h4;
  localparam logic [ADDR_W-1:0] REG_ROI_ROW1 = 4'h5;
  localparam logic [ADDR_W-1:0] REG_CLIP_HI = 4'h6;
  localparam logic [ADDR_W-1:0] REG_CLIP_LO = 4'h7;
  localparam logic [ADDR_W-1:0] REG_FRAMES = 4'h8;
  localparam int CTRL_AGC_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TABLE_BIT = 1;
  localparam logic RST_AGC_EN = 1'b0;
  localparam logic [COL_W-1:0] RST_ROI_COL0 = 7'h00;
  localparam logic [ROW_W-1:0] RST_ROI_ROW0 = 6'h00;
  localparam logic [COL_W-1:0] RST_ROI_COL1 = 7'h4F;
  localparam logic [ROW_W-1:0] RST_ROI_ROW1 = 6'h3B;
  localparam logic [CNT_W-1:0] RST_CLIP_HI = 16'h12C0;
  localparam logic [CNT_W-1:0] RST_CLIP_LO = 16'h0200;

  typedef enum logic [1:0] {
    ST_CLEAR = 2'b00,
    ST_RUN = 2'b01,
    ST_SUM = 2'b10,
    ST_MAP = 2'b11
  } agc_state_t;

endpackage

/* File: design/pixel_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module pixel_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] count_q;
  logic [PW:0] count_d;
  logic ready_q;
  logic valid_q;
  wire push = in_valid && ready_q;
  wire pop = out_ready && valid_q;

  // ready and valid are registered from the next count so that
  // full and empty never glitch toward the neighbours
  assign count_d = count_q + (PW+1)'(push) - (PW+1)'(pop);
  assign in_ready = ready_q;
  assign out_valid = valid_q;
  assign out_data = mem_q[rd_q];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
      ready_q <= 1'b1;
      valid_q <= 1'b0;
    end else begin
      count_q <= count_d;
      ready_q <= (count_d != (PW+1)'(DEPTH));
      valid_q <= (count_d != '0);
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

endmodule

`default_nettype wire

/* File: design/bin_shaper.sv */
`timescale 1ns/1ps
`default_nettype none

module bin_shaper (
  input wire logic [agc_pkg::CNT_W-1:0] count,
  input wire logic [agc_pkg::CNT_W-1:0] clip_hi,
  input wire logic [agc_pkg::CNT_W-1:0] clip_lo,
  output logic [agc_pkg::CNT_W:0] shaped
);

  wire [agc_pkg::CNT_W-1:0] capped = (count > clip_hi) ? clip_hi : count;
  // empty bins get no offset, so gaps in the input range stay gaps
  wire [agc_pkg::CNT_W-1:0] offset = (count != '0) ? clip_lo : '0;

  assign shaped = {1'b0, capped} + {1'b0, offset};

endmodule

`default_nettype wire

/* File: design/histogram_agc_mapper.sv */
// Contract
// - two modes, off and on; after reset off, pixels pass unmapped
// - with gain control on, each 14-bit pixel becomes an 8-bit grayshade
// - every frame, count pixels per possible 14-bit value
// - mapping comes from cumulative sum of processed bins
// - each bin is capped at the high clip value before accumulation
// - low clip constant added to nonzero bins only; empty bins stay zero
// - without a smaller region, every pixel of the array is counted
// - pixels outside a programmed region are left out of the counts
// - mapping applies to every pixel, inside or outside the region; all output
// - with gain on and no colorization, output is the 8-bit grayshade
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module histogram_agc_mapper (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic [agc_pkg::PIX_W-1:0] pix_data,
  input wire logic pix_sof,
  output logic out_valid,
  output logic [agc_pkg::PIX_W-1:0] out_data,
  output logic out_sof,
  input wire logic [agc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [agc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [agc_pkg::DATA_W-1:0] reg_rdata
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int FW = agc_pkg::PIX_W + 1;

  agc_pkg::agc_state_t state_q;
  agc_pkg::agc_state_t state_d;
  logic agc_en_q;
  logic [agc_pkg::COL_W-1:0] roi_col0_q;
  logic [agc_pkg::ROW_W-1:0] roi_row0_q;
  logic [agc_pkg::COL_W-1:0] roi_col1_q;
  logic [agc_pkg::ROW_W-1:0] roi_row1_q;
  logic [agc_pkg::CNT_W-1:0] clip_hi_q;
  logic [agc_pkg::CNT_W-1:0] clip_lo_q;
  logic [agc_pkg::DATA_W-1:0] frames_q;
  logic [agc_pkg::DATA_W-1:0] reg_rdata_q;
  logic table_valid_q;
  logic [agc_pkg::IDX_W-1:0] idx_q;
  logic [agc_pkg::ACC_W-1:0] total_q;
  logic [agc_pkg::ACC_W-1:0] cum_q;
  logic [agc_pkg::COL_W-1:0] col_q;
  logic [agc_pkg::ROW_W-1:0] row_q;
  logic out_valid_q;
  logic [agc_pkg::PIX_W-1:0] out_data_q;
  logic out_sof_q;
  logic [agc_pkg::CNT_W-1:0] hist_q [agc_pkg::BINS];
  logic [agc_pkg::OUT_W-1:0] map_q [agc_pkg::BINS];

  logic f_valid;
  logic f_ready;
  logic [FW-1:0] f_data;
  logic [agc_pkg::CNT_W:0] shaped;

  // ----------------------------------------------------------------
  // input buffer
  // ----------------------------------------------------------------
  // while the table is rebuilt the drain side stops, so the buffer
  // fills and pix_ready drops toward the pixel source
  pixel_fifo #(
    .WIDTH(FW),
    .DEPTH(agc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(pix_valid),
    .in_ready(pix_ready),
    .in_data({pix_sof, pix_data}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // ----------------------------------------------------------------
  // pixel position and region test
  // ----------------------------------------------------------------
  wire [agc_pkg::PIX_W-1:0] px = f_data[agc_pkg::PIX_W-1:0];
  wire px_sof = f_data[agc_pkg::PIX_W];
  wire running = (state_q == agc_pkg::ST_RUN);
  assign f_ready = running;
  wire take = f_valid && running;
  // a start-of-frame marker realigns the raster counters
  wire [agc_pkg::COL_W-1:0] cur_col = px_sof ? '0 : col_q;
  wire [agc_pkg::ROW_W-1:0] cur_row = px_sof ? '0 : row_q;
  wire last_col = (cur_col == agc_pkg::LAST_COL);
  wire frame_end = last_col && (cur_row == agc_pkg::LAST_ROW);
  wire in_roi = (cur_col >= roi_col0_q) && (cur_col <= roi_col1_q)
              && (cur_row >= roi_row0_q) && (cur_row <= roi_row1_q);
  wire count_px = take && agc_en_q && in_roi;

  // ----------------------------------------------------------------
  // table build arithmetic
  // ----------------------------------------------------------------
  bin_shaper u_shaper (
    .count(hist_q[idx_q]),
    .clip_hi(clip_hi_q),
    .clip_lo(clip_lo_q),
    .shaped(shaped)
  );

  wire [agc_pkg::ACC_W-1:0] shaped_w = agc_pkg::ACC_W'(shaped);
  wire [agc_pkg::ACC_W-1:0] cum_next = cum_q + shaped_w;
  // cum_next never exceeds total_q, so the quotient fits 0..255
  wire [agc_pkg::ACC_W+7:0] scaled_num = {8'h00, cum_next} * {32'h0000_0000, agc_pkg::GRAY_MAX};
  wire [agc_pkg::ACC_W+7:0] scaled_den = {8'h00, total_q};
  wire [agc_pkg::ACC_W+7:0] quot = (total_q == '0) ? '0 : scaled_num / scaled_den;
  wire [agc_pkg::OUT_W-1:0] gray_new = quot[agc_pkg::OUT_W-1:0];
  wire idx_last = (idx_q == agc_pkg::LAST_IDX);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      agc_pkg::ST_CLEAR: begin
        if (idx_last) begin
          state_d = agc_pkg::ST_RUN;
        end
      end
      agc_pkg::ST_RUN: begin
        if (take && frame_end && agc_en_q) begin
          state_d = agc_pkg::ST_SUM;
        end
      end
      agc_pkg::ST_SUM: begin
        if (idx_last) begin
          state_d = agc_pkg::ST_MAP;
        end
      end
      agc_pkg::ST_MAP: begin
        if (idx_last) begin
          state_d = agc_pkg::ST_RUN;
        end
      end
      default: begin
        state_d = agc_pkg::ST_CLEAR;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= agc_pkg::ST_CLEAR;
      idx_q <= '0;
    end else begin
      state_q <= state_d;
      if (running) begin
        idx_q <= '0;
      end else begin
        idx_q <= idx_q + 1'b1;
      end
    end
  end

  // first pass totals the shaped bins, second pass writes the table
  always_ff @(posedge clk) begin
    if (!nrst) begin
      total_q <= '0;
      cum_q <= '0;
      table_valid_q <= 1'b0;
      frames_q <= '0;
    end else begin
      if (running) begin
        total_q <= '0;
        cum_q <= '0;
      end else if (state_q == agc_pkg::ST_SUM) begin
        total_q <= total_q + shaped_w;
      end else if (state_q == agc_pkg::ST_MAP) begin
        cum_q <= cum_next;
      end
      if ((state_q == agc_pkg::ST_MAP) && idx_last) begin
        table_valid_q <= 1'b1;
        frames_q <= frames_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // histogram and mapping storage
  // ----------------------------------------------------------------
  // bins are zeroed as they are read in the second pass, so the next
  // frame starts from an empty histogram without an extra sweep
  always_ff @(posedge clk) begin
    if ((state_q == agc_pkg::ST_CLEAR) || (state_q == agc_pkg::ST_MAP)) begin
      hist_q[idx_q] <= '0;
    end else if (count_px && (hist_q[px] != '1)) begin
      hist_q[px] <= hist_q[px] + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (state_q == agc_pkg::ST_MAP) begin
      map_q[idx_q] <= gray_new;
    end
  end

  // ----------------------------------------------------------------
  // raster counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      col_q <= '0;
      row_q <= '0;
    end else if (take) begin
      if (frame_end) begin
        col_q <= '0;
        row_q <= '0;
      end else if (last_col) begin
        col_q <= '0;
        row_q <= cur_row + 1'b1;
      end else begin
        col_q <= cur_col + 1'b1;
        row_q <= cur_row;
      end
    end
  end

  // ----------------------------------------------------------------
  // pixel output
  // ----------------------------------------------------------------
  // before the first table exists the top bits serve as a linear stand-in
  wire [agc_pkg::OUT_W-1:0] gray_out = table_valid_q ? map_q[px]
                                     : px[agc_pkg::PIX_W-1:agc_pkg::PIX_W-agc_pkg::OUT_W];
  wire [agc_pkg::PIX_W-1:0] mapped_px = {6'h00, gray_out};
  wire [agc_pkg::PIX_W-1:0] out_sel = agc_en_q ? mapped_px : px;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
      out_sof_q <= 1'b0;
    end else begin
      out_valid_q <= take;
      if (take) begin
        out_data_q <= out_sel;
        out_sof_q <= px_sof;
      end
    end
  end

  assign out_valid = out_valid_q;
  assign out_data = out_data_q;
  assign out_sof = out_sof_q;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  wire wr_ctrl = reg_wr && (reg_addr == agc_pkg::REG_CTRL);
  wire wr_col0 = reg_wr && (reg_addr == agc_pkg::REG_ROI_COL0);
  wire wr_row0 = reg_wr && (reg_addr == agc_pkg::REG_ROI_ROW0);
  wire wr_col1 = reg_wr && (reg_addr == agc_pkg::REG_ROI_COL1);
  wire wr_row1 = reg_wr && (reg_addr == agc_pkg::REG_ROI_ROW1);
  wire wr_hi = reg_wr && (reg_addr == agc_pkg::REG_CLIP_HI);
  wire wr_lo = reg_wr && (reg_addr == agc_pkg::REG_CLIP_LO);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      agc_en_q <= agc_pkg::RST_AGC_EN;
      roi_col0_q <= agc_pkg::RST_ROI_COL0;
      roi_row0_q <= agc_pkg::RST_ROI_ROW0;
      roi_col1_q <= agc_pkg::RST_ROI_COL1;
      roi_row1_q <= agc_pkg::RST_ROI_ROW1;
      clip_hi_q <= agc_pkg::RST_CLIP_HI;
      clip_lo_q <= agc_pkg::RST_CLIP_LO;
    end else begin
      if (wr_ctrl) begin
        agc_en_q <= reg_wdata[agc_pkg::CTRL_AGC_BIT];
      end
      if (wr_col0) begin
        roi_col0_q <= reg_wdata[agc_pkg::COL_W-1:0];
      end
      if (wr_row0) begin
        roi_row0_q <= reg_wdata[agc_pkg::ROW_W-1:0];
      end
      if (wr_col1) begin
        roi_col1_q <= reg_wdata[agc_pkg::COL_W-1:0];
      end
      if (wr_row1) begin
        roi_row1_q <= reg_wdata[agc_pkg::ROW_W-1:0];
      end
      if (wr_hi) begin
        clip_hi_q <= reg_wdata;
      end
      if (wr_lo) begin
        clip_lo_q <= reg_wdata;
      end
    end
  end

  wire [agc_pkg::DATA_W-1:0] status_w;
  assign status_w = {14'h0000, table_valid_q, ~running};

  logic [agc_pkg::DATA_W-1:0] rd_sel;
  always_comb begin
    if (reg_addr == agc_pkg::REG_CTRL) begin
      rd_sel = {15'h0000, agc_en_q};
    end else if (reg_addr == agc_pkg::REG_STATUS) begin
      rd_sel = status_w;
    end else if (reg_addr == agc_pkg::REG_ROI_COL0) begin
      rd_sel = {9'h000, roi_col0_q};
    end else if (reg_addr == agc_pkg::REG_ROI_ROW0) begin
      rd_sel = {10'h000, roi_row0_q};
    end else if (reg_addr == agc_pkg::REG_ROI_COL1) begin
      rd_sel = {9'h000, roi_col1_q};
    end else if (reg_addr == agc_pkg::REG_ROI_ROW1) begin
      rd_sel = {10'h000, roi_row1_q};
    end else if (reg_addr == agc_pkg::REG_CLIP_HI) begin
      rd_sel = clip_hi_q;
    end else if (reg_addr == agc_pkg::REG_CLIP_LO) begin
      rd_sel = clip_lo_q;
    end else if (reg_addr == agc_pkg::REG_FRAMES) begin
      rd_sel = frames_q;
    end else begin
      rd_sel = 16'h0000;
    end
  end

  // read data holds only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_sel;
    end else begin
      reg_rdata_q <= '0;
    end
  end

  assign reg_rdata = reg_rdata_q;

endmodule

`default_nettype wire

/* File: tb/agc_props.sv */
`timescale 1ns/1ps
`default_nettype none

module agc_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic [agc_pkg::PIX_W-1:0] pix_data,
  input wire logic pix_sof,
  input wire logic out_valid,
  input wire logic [agc_pkg::PIX_W-1:0] out_data,
  input wire logic out_sof,
  input wire logic [agc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [agc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [agc_pkg::DATA_W-1:0] reg_rdata
);
  // ----
  // shadow of writable fields
  // ----
  logic gain_q;
  logic seen_q;
  logic [6:0] col0_q;
  logic [6:0] col1_q;
  logic [15:0] hi_q;
  logic [15:0] lo_q;
  logic [15:0] age_q;

  // age_q saturates past the clear sweep; raw latency is only fixed once gain never ran
  always_ff @(posedge clk) begin
    if (!nrst) begin
      gain_q <= 1'b0;
      seen_q <= 1'b0;
      col0_q <= 7'h00;
      col1_q <= 7'h4F;
      hi_q <= 16'h12C0;
      lo_q <= 16'h0200;
      age_q <= 16'h0000;
    end else begin
      if (age_q != 16'h4020) age_q <= age_q + 16'h0001;
      if (gain_q) seen_q <= 1'b1;
      if (reg_wr && reg_addr == agc_pkg::REG_CTRL) gain_q <= reg_wdata[0];
      if (reg_wr && reg_addr == agc_pkg::REG_ROI_COL0) col0_q <= reg_wdata[6:0];
      if (reg_wr && reg_addr == agc_pkg::REG_ROI_COL1) col1_q <= reg_wdata[6:0];
      if (reg_wr && reg_addr == agc_pkg::REG_CLIP_HI) hi_q <= reg_wdata;
      if (reg_wr && reg_addr == agc_pkg::REG_CLIP_LO) lo_q <= reg_wdata;
    end
  end

  // ----
  // assertions
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  AST_CTRL_RB: assert property (reg_rd && reg_addr == agc_pkg::REG_CTRL
    |=> reg_rdata == {15'h0000, gain_q}) else $error("gain readback wrong");
  AST_HI_RB: assert property (reg_rd && reg_addr == agc_pkg::REG_CLIP_HI
    |=> reg_rdata == hi_q) else $error("clip high readback wrong");
  AST_LO_RB: assert property (reg_rd && reg_addr == agc_pkg::REG_CLIP_LO
    |=> reg_rdata == lo_q) else $error("clip low readback wrong");
  AST_COL1_RB: assert property (reg_rd && reg_addr == agc_pkg::REG_ROI_COL1
    |=> reg_rdata == {9'h000, col1_q}) else $error("last column readback wrong");
  AST_COL0_RB: assert property (reg_rd && reg_addr == agc_pkg::REG_ROI_COL0
    |=> reg_rdata == {9'h000, col0_q}) else $error("first column readback wrong");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  AST_RST_QUIET: assert property ($rose(nrst) |-> !out_valid && !out_sof
    && out_data == 14'h0000 && reg_rdata == 16'h0000) else $error("outputs not cleared");
  AST_RAW_PASS: assert property (pix_valid && pix_ready && !gain_q && !seen_q
    && age_q == 16'h4020 |-> ##2 out_valid && out_data == $past(pix_data, 2)
    && out_sof == $past(pix_sof, 2)) else $error("raw pixel not passed");
  AST_GRAY_TOP: assert property (out_valid && gain_q && $past(gain_q, 4)
    |-> out_data[13:8] == 6'h00) else $error("grayshade upper bits set");

  COV_GAIN_OUT: cover property (out_valid && gain_q);
  COV_STALL: cover property (pix_valid && !pix_ready);
  COV_READ: cover property (reg_rd ##1 reg_rdata != 16'h0000);
endmodule

`default_nettype wire

/* File: tb/host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input wire logic clk,
  output logic [agc_pkg::ADDR_W-1:0] reg_addr,
  output logic [agc_pkg::DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [agc_pkg::DATA_W-1:0] reg_rdata
);
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // tasks are entered just after a rising edge and leave one edge after the strobe drops
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    // read data stand for exactly the cycle after the strobe: take them at its closing edge
    @(posedge clk);
    v = reg_rdata;
  endtask
endmodule

`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
  logic clk, nrst, pix_valid, pix_ready, pix_sof, out_valid, out_sof, reg_wr, reg_rd;
  logic [13:0] pix_data, out_data;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [13:0] q[$];
  typedef struct packed {logic [3:0] a; logic [15:0] e;} row_t;
  row_t rows [9] = '{'{4'h0, 16'h0000}, '{4'h2, 16'h0000}, '{4'h3, 16'h0000},
    '{4'h4, 16'h004F}, '{4'h5, 16'h003B}, '{4'h6, 16'h12C0}, '{4'h7, 16'h0200},
    '{4'h8, 16'h0000}, '{4'hF, 16'h0000}};

  histogram_agc_mapper u_histogram_agc_mapper (.clk(clk), .nrst(nrst),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data), .pix_sof(pix_sof),
    .out_valid(out_valid), .out_data(out_data), .out_sof(out_sof), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  host_model u_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (out_valid === 1'b1) q.push_back(out_data);
    cyc++;
    if (cyc == 90000) begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("errors=%0d checks=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // valid stays up between pixels so it is never driven twice in one step
  task automatic send(input logic [13:0] d, input logic s);
    pix_valid <= 1'b1;
    pix_data <= d;
    pix_sof <= s;
    @(posedge clk);
    while (pix_ready !== 1'b1) @(posedge clk);
  endtask

  task automatic idle();
    pix_valid <= 1'b0;
    pix_data <= ~pix_data;
    pix_sof <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    nrst = 1'b0;
    pix_valid = 1'b0;
    pix_data = 14'h0000;
    pix_sof = 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      u_host_model.rd(rows[i].a, v);
      `CHK(v, rows[i].e)
    end
    v = 16'hFFFF;
    for (int i = 0; i < 10000 && v[0] !== 1'b0; i++) u_host_model.rd(4'h1, v);
    `CHK(v[0], 1'b0)
    repeat (40) @(posedge clk);
    q.delete();
    send(14'h3FFF, 1'b1);
    send(14'h1234, 1'b0);
    send(14'h0001, 1'b0);
    idle();
    repeat (4) @(posedge clk);
    `CHK({q[0], q[1], q[2]}, {14'h3FFF, 14'h1234, 14'h0001})
    // region is columns 0..9: col 0 low bin, cols 1..9 high bin, rest lower and excluded
    u_host_model.wr(4'h4, 16'h0009);
    u_host_model.wr(4'h6, 16'h0190);
    u_host_model.wr(4'h7, 16'h0064);
    u_host_model.wr(4'h8, 16'h1234);
    u_host_model.wr(4'h0, 16'h0001);
    q.delete();
    for (int r = 0; r < 60; r++) begin
      for (int c = 0; c < 80; c++) begin
        send(c == 0 ? 14'h0100 : (c < 10 ? 14'h0200 : 14'h0050), r == 0 && c == 0);
      end
    end
    idle();
    repeat (8) @(posedge clk);
    `CHK(q.size(), 4800)
    `CHK(q[0], 14'h0004)
    u_host_model.rd(4'h1, v);
    `CHK(v[0], 1'b1)
    q.delete();
    send(14'h0100, 1'b1);
    send(14'h0200, 1'b0);
    send(14'h0050, 1'b0);
    send(14'h00FF, 1'b0);
    idle();
    #1;
    `CHK(pix_ready, 1'b0)
    @(posedge clk);
    send(14'h0180, 1'b0);
    idle();
    for (int i = 0; i < 60000 && q.size() < 5; i++) @(posedge clk);
    `CHK(q.size(), 5)
    // bins 160 and 500 of 660: low value maps to floor(160*255/660)
    `CHK({q[0], q[1], q[2], q[3], q[4]}, {14'h3D, 14'hFF, 14'h0, 14'h0, 14'h3D})
    u_host_model.rd(4'h8, v);
    `CHK(v, 16'h0001)
    u_host_model.rd(4'h1, v);
    `CHK(v, 16'h0002)
    stop_test();
  end
endmodule

bind histogram_agc_mapper agc_props u_agc_props (.clk(clk), .nrst(nrst),
  .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data), .pix_sof(pix_sof),
  .out_valid(out_valid), .out_data(out_data), .out_sof(out_sof), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

`default_nettype wire
